// ==== hdl/cmp_timer_pkg.sv ====
package cmp_timer_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TIMER_LOW = 8'h04;
  localparam logic [7:0] OFS_TIMER_HIGH = 8'h08;
  localparam logic [7:0] OFS_COMPARE_ONE = 8'h0c;
  localparam logic [7:0] OFS_UNIT_ONE_CONTROL = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_COMPARE_TWO = 8'h18;
  localparam logic [7:0] OFS_UNIT_TWO_CONTROL = 8'h1c;
  localparam logic [7:0] OFS_PWM_PERIOD = 8'h20;
  localparam logic [7:0] OFS_PWM_DUTY = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // timer_control fields
  localparam int TCTL_ON_BIT = 0;
  localparam int TCTL_PRE_LSB = 4;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;

  // unit control fields
  localparam int UCTL_DUTY_LSB = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT_INT = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_CMP_TOP = 2'h2;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // flag register bits
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_U1_BIT = 1;
  localparam int FLAG_U2_BIT = 2;
  localparam int FLAG_W = 3;

  // status register bits
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_PWM_BIT = 1;

  localparam int UNITS = 2;
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [1:0] PWM_FINE_TOP = 2'h3;
endpackage

// ==== hdl/pair_timer.sv ====
`timescale 1ns/1ps
module pair_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] prescale,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire logic clear,
  output logic [15:0] count,
  output logic stepped,
  output logic ovf
);
  logic [2:0] presc;
  logic [2:0] presc_top;
  logic tick;

  assign presc_top = 3'(({1'b0, 2'h0} + 3'h1 << prescale) - 3'h1);
  assign tick = run && (presc == presc_top);
  assign ovf = tick && (count == cmp_timer_pkg::TIMER_MAX) && !wr_low && !wr_high && !clear;

  ////////////////////////////////////////////////////////////////////////////////
  // any write to either byte restarts the prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc <= 3'h0;
    end else if (wr_low || wr_high) begin
      presc <= 3'h0;
    end else if (!run || tick) begin
      presc <= 3'h0;
    end else begin
      presc <= presc + 3'h1;
    end
  end

  // the count has no reset on purpose: it survives every reset
  always_ff @(posedge clk) begin
    if (wr_low || wr_high) begin
      if (wr_low) begin
        count[7:0] <= wdata;
      end
      if (wr_high) begin
        count[15:8] <= wdata;
      end
    end else if (clear) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepped <= 1'b0;
    end else begin
      stepped <= tick && !wr_low && !wr_high && !clear;
    end
  end

  chk_prescale_cleared: assert property (@(posedge clk) disable iff (rst)
    (wr_low || wr_high) |=> (presc == 3'h0))
    else $error("prescaler not cleared by timer write");
endmodule

// ==== hdl/compare_pwm_timer_link.sv ====
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module compare_pwm_timer_link (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic OTHER_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONVERTER_ON,
  output logic UNIT_ONE_PIN,
  output logic CONVERT_START
);
  logic [7:0] timer_control;
  logic [15:0] compare_value [cmp_timer_pkg::UNITS];
  logic [3:0] unit_mode [cmp_timer_pkg::UNITS];
  logic [1:0] duty_low;
  logic [7:0] duty_high;
  logic [7:0] pwm_period;
  logic [cmp_timer_pkg::FLAG_W-1:0] flags;
  logic [cmp_timer_pkg::FLAG_W-1:0] flag_set;
  logic [9:0] pwm_count;
  logic [9:0] duty_latched;
  logic pwm_mode;
  logic trig_q;
  logic [15:0] timer_count;
  logic stepped;
  logic ovf;
  logic [cmp_timer_pkg::UNITS-1:0] match_evt;
  logic [cmp_timer_pkg::UNITS-1:0] trig;
  logic access;
  logic take;
  logic wr;
  logic wr_low;
  logic wr_high;
  logic [31:0] rd_value;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, answer registered
  assign access = PSEL && PENABLE;
  assign take = access && PREADY;
  assign wr = take && PWRITE;
  assign wr_low = wr && (PADDR == cmp_timer_pkg::OFS_TIMER_LOW);
  assign wr_high = wr && (PADDR == cmp_timer_pkg::OFS_TIMER_HIGH);

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_err = 1'b0;
    case (PADDR)
      cmp_timer_pkg::OFS_TIMER_CONTROL: rd_value = {24'h000000, timer_control};
      cmp_timer_pkg::OFS_TIMER_LOW: rd_value = {24'h000000, timer_count[7:0]};
      cmp_timer_pkg::OFS_TIMER_HIGH: rd_value = {24'h000000, timer_count[15:8]};
      cmp_timer_pkg::OFS_COMPARE_ONE: rd_value = {16'h0000, compare_value[0]};
      cmp_timer_pkg::OFS_UNIT_ONE_CONTROL: rd_value = {26'h0000000, duty_low, unit_mode[0]};
      cmp_timer_pkg::OFS_FLAGS: rd_value = {29'h00000000, flags};
      cmp_timer_pkg::OFS_COMPARE_TWO: rd_value = {16'h0000, compare_value[1]};
      cmp_timer_pkg::OFS_UNIT_TWO_CONTROL: rd_value = {28'h0000000, unit_mode[1]};
      cmp_timer_pkg::OFS_PWM_PERIOD: rd_value = {24'h000000, pwm_period};
      cmp_timer_pkg::OFS_PWM_DUTY: rd_value = {24'h000000, duty_high};
      cmp_timer_pkg::OFS_STATUS: rd_value = {30'h00000000, pwm_mode, UNIT_ONE_PIN};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= access && !PREADY;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (access && !PREADY) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_value;
      PSLVERR <= rd_err;
    end else begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer control: only the power-on / brown-out reset touches it
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      timer_control <= cmp_timer_pkg::TIMER_CONTROL_RESET;
    end else if (wr && PADDR == cmp_timer_pkg::OFS_TIMER_CONTROL) begin
      timer_control <= PWDATA[7:0];
    end
  end

  // configuration registers, cleared by every reset
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      compare_value[0] <= 16'h0000;
      compare_value[1] <= 16'h0000;
      unit_mode[0] <= cmp_timer_pkg::MODE_OFF;
      unit_mode[1] <= cmp_timer_pkg::MODE_OFF;
      duty_low <= 2'h0;
      duty_high <= 8'h00;
      pwm_period <= 8'h00;
    end else if (OTHER_RST) begin
      compare_value[0] <= 16'h0000;
      compare_value[1] <= 16'h0000;
      unit_mode[0] <= cmp_timer_pkg::MODE_OFF;
      unit_mode[1] <= cmp_timer_pkg::MODE_OFF;
      duty_low <= 2'h0;
      duty_high <= 8'h00;
      pwm_period <= 8'h00;
    end else if (wr) begin
      case (PADDR)
        cmp_timer_pkg::OFS_COMPARE_ONE: compare_value[0] <= PWDATA[15:0];
        cmp_timer_pkg::OFS_COMPARE_TWO: compare_value[1] <= PWDATA[15:0];
        cmp_timer_pkg::OFS_UNIT_ONE_CONTROL: begin
          unit_mode[0] <= PWDATA[3:0];
          duty_low <= PWDATA[cmp_timer_pkg::UCTL_DUTY_LSB +: 2];
        end
        cmp_timer_pkg::OFS_UNIT_TWO_CONTROL: unit_mode[1] <= PWDATA[3:0];
        cmp_timer_pkg::OFS_PWM_PERIOD: pwm_period <= PWDATA[7:0];
        cmp_timer_pkg::OFS_PWM_DUTY: duty_high <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer pair
  pair_timer u_timer (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .run(timer_control[cmp_timer_pkg::TCTL_ON_BIT]),
    .prescale(timer_control[cmp_timer_pkg::TCTL_PRE_LSB +: 2]),
    .wr_low(wr_low),
    .wr_high(wr_high),
    .wdata(PWDATA[7:0]),
    .clear(trig_q),
    .count(timer_count),
    .stepped(stepped),
    .ovf(ovf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare units: a match is the step that lands on the compare value,
  // so a stopped timer resting on it does not fire again
  generate
    for (genvar u = 0; u < cmp_timer_pkg::UNITS; u++) begin : g_unit
      assign match_evt[u] = stepped && (timer_count == compare_value[u]) &&
                            (unit_mode[u][3:2] == cmp_timer_pkg::MODE_CMP_TOP);
      assign trig[u] = match_evt[u] && (unit_mode[u] == cmp_timer_pkg::MODE_SPECIAL);
    end
  endgenerate

  // trigger is registered; the timer sees it as a clear one cycle later
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      trig_q <= 1'b0;
      CONVERT_START <= 1'b0;
    end else begin
      trig_q <= |trig;
      CONVERT_START <= trig[1] && CONVERTER_ON;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  assign flag_set = {match_evt[1], match_evt[0], ovf};

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      flags <= 3'h0;
    end else if (OTHER_RST) begin
      flags <= 3'h0;
    end else if (wr && PADDR == cmp_timer_pkg::OFS_FLAGS) begin
      flags <= (flags & ~PWDATA[cmp_timer_pkg::FLAG_W-1:0]) | flag_set;
    end else begin
      flags <= flags | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pwm: 8-bit period plus 2 fine bits gives a 10-bit time base;
  // in pwm mode the duty is only taken at the period boundary to avoid glitches
  assign pwm_mode = (unit_mode[0][3:2] == cmp_timer_pkg::MODE_PWM_TOP);

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwm_count <= 10'h000;
      duty_latched <= 10'h000;
    end else if (!pwm_mode) begin
      pwm_count <= 10'h000;
      duty_latched <= {duty_high, duty_low};
    end else if (pwm_count == {pwm_period, cmp_timer_pkg::PWM_FINE_TOP}) begin
      pwm_count <= 10'h000;
      duty_latched <= {duty_high, duty_low};
    end else begin
      pwm_count <= pwm_count + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output latch, separate from any port data latch
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      UNIT_ONE_PIN <= 1'b0;
    end else if (OTHER_RST || unit_mode[0] == cmp_timer_pkg::MODE_OFF) begin
      UNIT_ONE_PIN <= 1'b0;
    end else if (pwm_mode) begin
      UNIT_ONE_PIN <= (pwm_count < duty_latched);
    end else if (match_evt[0] && unit_mode[0] == cmp_timer_pkg::MODE_SET_HIGH) begin
      UNIT_ONE_PIN <= 1'b1;
    end else if (match_evt[0] && unit_mode[0] == cmp_timer_pkg::MODE_SET_LOW) begin
      UNIT_ONE_PIN <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_trig_then_clear;
    trig[0] ##1 (trig_q && !wr_low && !wr_high);
  endsequence

  chk_match_sets_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || OTHER_RST)
    match_evt[0] |=> flags[cmp_timer_pkg::FLAG_U1_BIT])
    else $error("unit one match did not set its flag");

  chk_match_drives_high: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || OTHER_RST)
    (match_evt[0] && unit_mode[0] == cmp_timer_pkg::MODE_SET_HIGH) |=> UNIT_ONE_PIN)
    else $error("pin not driven high on match");

  chk_match_drives_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || OTHER_RST)
    (match_evt[0] && unit_mode[0] == cmp_timer_pkg::MODE_SET_LOW) |=> !UNIT_ONE_PIN)
    else $error("pin not driven low on match");

  chk_soft_int_pin: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || OTHER_RST)
    (unit_mode[0] == cmp_timer_pkg::MODE_SOFT_INT) |=> $stable(UNIT_ONE_PIN))
    else $error("pin moved in software interrupt mode");

  chk_off_forces_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (unit_mode[0] == cmp_timer_pkg::MODE_OFF) |=> !UNIT_ONE_PIN)
    else $error("output latch not low with control cleared");

  chk_trigger_clears: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    s_trig_then_clear |=> (timer_count == 16'h0000))
    else $error("special event trigger did not clear the timer");

  chk_conv_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (trig[1] && CONVERTER_ON) |=> (CONVERT_START && trig_q))
    else $error("unit two trigger did not start a conversion");

  chk_clear_no_ovf: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    trig_q |-> !ovf)
    else $error("trigger clear raised overflow");

  chk_write_wins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (trig_q && wr_low) |=> (timer_count[7:0] == $past(PWDATA[7:0])))
    else $error("trigger clear beat a timer write");

  chk_ctl_kept: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (OTHER_RST && !wr) |=> $stable(timer_control))
    else $error("timer control changed on a non power-on reset");

  chk_pwm_level: assert property (@(posedge CLK_SYS) disable iff (SYS_RST || OTHER_RST)
    pwm_mode |=> (UNIT_ONE_PIN == ($past(pwm_count) < $past(duty_latched))))
    else $error("pwm level does not follow duty compare");
endmodule

// ==== tb/converter_model.sv ====
`timescale 1ns/1ps
module converter_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic power,
  input wire logic start,
  output logic converter_on,
  output int starts,
  output int strays
);
  assign converter_on = power;
  // a start while switched off is counted apart so the bench can flag it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      starts <= 0;
      strays <= 0;
    end else if (start && converter_on) begin
      starts <= starts + 1;
    end else if (start) begin
      strays <= strays + 1;
    end
  end
endmodule

// ==== tb/compare_pwm_timer_link_tb.sv ====
`timescale 1ns/1ps
module compare_pwm_timer_link_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic other_rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic conv_power = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready, pslverr, conv_on, pin, conv_start, errv;
  int starts, strays, s, highs;
  int n_errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  compare_pwm_timer_link dut_u (.CLK_SYS(clk), .SYS_RST(rst), .OTHER_RST(other_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CONVERTER_ON(conv_on), .UNIT_ONE_PIN(pin),
    .CONVERT_START(conv_start));
  converter_model conv_u (.clk(clk), .rst(rst), .power(conv_power), .start(conv_start),
    .converter_on(conv_on), .starts(starts), .strays(strays));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one extra edge after release so back-to-back calls never drive psel twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) cmp("apb answer", 32'h1, 32'h0);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rdv);
  endtask

  task automatic set_timer(input logic [15:0] v);
    wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h0);
    wr(cmp_timer_pkg::OFS_TIMER_LOW, {24'h0, v[7:0]});
    wr(cmp_timer_pkg::OFS_TIMER_HIGH, {24'h0, v[15:8]});
  endtask

  // timer starts at st, runs at 1:1 in timer mode, match due 8 steps later when c = st + 8
  task automatic run_match(input logic [3:0] mode, input logic [15:0] st, input logic [15:0] c,
    input logic [31:0] flags);
    set_timer(st);
    wr(cmp_timer_pkg::OFS_COMPARE_ONE, {16'h0, c});
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, {28'h0, mode});
    wr(cmp_timer_pkg::OFS_FLAGS, 32'h7);
    wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h1);
    repeat (12) @(posedge clk);
    rd(cmp_timer_pkg::OFS_FLAGS, flags, "match flags");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h0, "control after power-on");
    apb(1'b0, 8'h3c, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, errv});
    $display("test registers done");
    // a low-byte-only compare would hit at 0x0020
    run_match(cmp_timer_pkg::MODE_SET_HIGH, 16'h0018, 16'h0120, 32'h0);
    cmp("pin no match", 32'h0, {31'h0, pin});
    run_match(cmp_timer_pkg::MODE_SET_HIGH, 16'h0118, 16'h0120, 32'h2);
    cmp("pin set high", 32'h1, {31'h0, pin});
    run_match(cmp_timer_pkg::MODE_SOFT_INT, 16'h0238, 16'h0240, 32'h2);
    cmp("pin untouched", 32'h1, {31'h0, pin});
    run_match(cmp_timer_pkg::MODE_SET_LOW, 16'h0358, 16'h0360, 32'h2);
    cmp("pin set low", 32'h0, {31'h0, pin});
    run_match(cmp_timer_pkg::MODE_SET_HIGH, 16'h0118, 16'h0120, 32'h2);
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, 32'h0);
    // the latch drops on the edge the task ends on; look one edge later
    @(posedge clk);
    cmp("latch cleared", 32'h0, {31'h0, pin});
    set_timer(16'h0120);
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, {28'h0, cmp_timer_pkg::MODE_SET_HIGH});
    repeat (4) @(posedge clk);
    cmp("no step no match", 32'h0, {31'h0, pin});
    $display("test compare done");
    run_match(cmp_timer_pkg::MODE_SPECIAL, 16'h0010, 16'h0018, 32'h2);
    wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h0);
    rd(cmp_timer_pkg::OFS_TIMER_HIGH, 32'h0, "timer high after clear");
    apb(1'b0, cmp_timer_pkg::OFS_TIMER_LOW, 32'h0);
    cmp("timer within period", 32'h1, {31'h0, rdv <= 32'h18});
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, 32'h0);
    wr(cmp_timer_pkg::OFS_COMPARE_TWO, 32'h18);
    wr(cmp_timer_pkg::OFS_UNIT_TWO_CONTROL, {28'h0, cmp_timer_pkg::MODE_SPECIAL});
    wr(cmp_timer_pkg::OFS_FLAGS, 32'h7);
    for (int p = 1; p >= 0; p--) begin
      conv_power <= p[0];
      s = starts;
      set_timer(16'h0010);
      wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h1);
      repeat (12) @(posedge clk);
      wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h0);
      cmp("conversions started", p, starts - s);
      rd(cmp_timer_pkg::OFS_TIMER_HIGH, 32'h0, "timer high unit two");
    end
    cmp("starts while off", 32'h0, strays);
    rd(cmp_timer_pkg::OFS_FLAGS, 32'h4, "no overflow flag");
    $display("test trigger done");
    set_timer(16'h1234);
    wr(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h30);
    other_rst <= 1'b1;
    repeat (2) @(posedge clk);
    other_rst <= 1'b0;
    @(posedge clk);
    rd(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h30, "control other reset");
    rd(cmp_timer_pkg::OFS_TIMER_LOW, 32'h34, "timer low other reset");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(cmp_timer_pkg::OFS_TIMER_CONTROL, 32'h0, "control power-on");
    rd(cmp_timer_pkg::OFS_TIMER_HIGH, 32'h12, "timer high power-on");
    $display("test resets done");
    // period 3 gives 16 counts; duty {1,2'b10} = 6 high counts per period
    wr(cmp_timer_pkg::OFS_PWM_PERIOD, 32'h3);
    wr(cmp_timer_pkg::OFS_PWM_DUTY, 32'h1);
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, 32'h2c);
    repeat (20) @(posedge clk);
    highs = 0;
    repeat (32) begin
      @(posedge clk);
      highs += pin;
    end
    cmp("pwm high cycles", 32'd12, highs);
    apb(1'b0, cmp_timer_pkg::OFS_STATUS, 32'h0);
    cmp("pwm mode status", 32'h2, rdv & 32'h2);
    wr(cmp_timer_pkg::OFS_UNIT_ONE_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    cmp("pwm latch cleared", 32'h0, {31'h0, pin});
    $display("test pwm done");
    end_of_test();
  end
endmodule
